// *** pkg/ccwd_pkg.sv ***
// Constants and types for the codec control word decoder
package ccwd_pkg;

  // ==========================================================
  // Control word layout
  localparam int WORD_W = 16;
  localparam int CTL_BIT = 15;
  localparam int RW_BIT = 14;
  localparam int DEV_HI = 13;
  localparam int DEV_LO = 11;
  localparam int RADR_HI = 10;
  localparam int RADR_LO = 8;
  localparam int DATA_HI = 7;

  // ==========================================================
  // Register addresses
  localparam logic [2:0] ADR_SERIAL = 3'h0;
  localparam logic [2:0] ADR_CLOCK = 3'h1;
  localparam logic [2:0] ADR_POWER = 3'h2;
  localparam logic [2:0] ADR_GAIN = 3'h3;
  localparam logic [2:0] ADR_DAC = 3'h4;
  localparam logic [2:0] ADR_TAP = 3'h5;
  localparam logic [2:0] DEV_SELF = 3'h0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] SERIAL_WMASK = 8'h7f;
  localparam logic [7:0] POWER_WMASK = 8'h7f;

  // ==========================================================
  // Field positions
  localparam int RUN_BIT = 0;
  localparam int MIXED_BIT = 1;
  localparam int DLOOP_BIT = 2;
  localparam int SLOOP_BIT = 3;
  localparam int CASC_LO = 4;
  localparam int CASC_HI = 6;
  localparam int SWRST_BIT = 7;
  localparam int RATE_LO = 0;
  localparam int RATE_HI = 1;
  localparam int SCLK_LO = 2;
  localparam int SCLK_HI = 3;
  localparam int MDIV_LO = 4;
  localparam int MDIV_HI = 6;
  localparam int ECHO_BIT = 7;
  localparam int PWR_ALL_BIT = 0;
  localparam int PWR_TAP_BIT = 1;
  localparam int PWR_AMP_BIT = 2;
  localparam int PWR_ADC_BIT = 3;
  localparam int PWR_DAC_BIT = 4;
  localparam int PWR_REF_BIT = 5;
  localparam int REF_PIN_BIT = 6;
  localparam int IGAIN_LO = 0;
  localparam int IGAIN_HI = 2;
  localparam int MODRST_BIT = 3;
  localparam int OGAIN_LO = 4;
  localparam int OGAIN_HI = 6;
  localparam int QUIET_BIT = 7;
  localparam int ADV_LO = 0;
  localparam int ADV_HI = 4;
  localparam int BYPASS_BIT = 5;
  localparam int DTAP_BIT = 6;
  localparam int TEST_BIT = 7;
  localparam int COEF_LO = 0;
  localparam int COEF_HI = 4;
  localparam int SINGLE_BIT = 5;
  localparam int FLIP_BIT = 6;
  localparam int LOOP_OUT_BIT = 7;

  // ==========================================================
  // Timing
  localparam int SYS_PER_MCLK = 2;
  localparam logic [2:0] RESET_DIVIDED_MASTER_CLOCK = 3'h4;
  localparam logic [3:0] SCLK_BASE = 4'h8;
  localparam logic [11:0] RATE_BASE = 12'h800;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] tap;
    logic [7:0] dac;
    logic [7:0] gain;
    logic [7:0] power;
    logic [7:0] clock;
    logic [7:0] serial;
  } ccwd_regs_t;

  typedef struct packed {
    logic run_mode_select;
    logic mixed_mode_on;
    logic digital_loopback;
    logic serial_port_loopback;
    logic [2:0] cascade_count;
    logic [1:0] sample_rate_sel;
    logic [1:0] serial_clock_sel;
    logic [2:0] master_divide_sel;
    logic control_echo_on;
    logic global_power_on;
    logic analog_tap_power;
    logic input_amp_power;
    logic adc_power;
    logic dac_power;
    logic reference_power;
    logic reference_pin_drive;
    logic [2:0] input_gain_sel;
    logic modulator_reset;
    logic [2:0] output_gain_sel;
    logic output_mute;
    logic [4:0] dac_advance;
    logic interpolator_bypass;
    logic digital_tap_enable;
    logic test_mode_on;
    logic [4:0] analog_tap_coef;
    logic single_ended_input;
    logic analog_tap_enable;
    logic input_polarity_flip;
    logic analog_loopback;
    logic analog_tap_mute;
  } ccwd_ctl_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_SHIFT = 2'b10
  } ccwd_rx_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } ccwd_tx_t;

endpackage : ccwd_pkg

// *** rtl/ccwd_decoder.sv ***
// Control word decoder and control register bank of one codec channel
`timescale 1ns/10ps
`default_nettype none
module ccwd_decoder #(
  parameter int SYS_PER_MCLK = ccwd_pkg::SYS_PER_MCLK
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic areset_n,
  input wire logic rx_data,
  input wire logic rx_frame,
  output logic ser_clk,
  output logic tx_data,
  output logic tx_frame,
  output wire ccwd_pkg::ccwd_ctl_t ctl,
  output logic [15:0] dac_word,
  output logic dac_valid,
  output logic sample_tick,
  output wire logic reset_busy
);

  // ==========================================================
  // Parameter check
  if (SYS_PER_MCLK < 2 || SYS_PER_MCLK > 1024 || (SYS_PER_MCLK % 2) != 0) begin : g_chk
    $error("SYS_PER_MCLK must be even and within 2..1024");
  end

  ccwd_pkg::ccwd_regs_t regs_reg;

  // ==========================================================
  // Pin synchronisers
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic hw_rst;
  logic rx_data_s;
  logic rx_frame_s;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      pin_s1_reg <= {areset_n, rx_data, rx_frame};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign hw_rst = ~pin_s2_reg[2];
  assign rx_data_s = pin_s2_reg[1];
  assign rx_frame_s = pin_s2_reg[0];

  // ==========================================================
  // Clock dividers
  // clk_sys stands for the master clock pin at SYS_PER_MCLK cycles per period,
  // so even the fastest serial clock keeps a true high and low phase.
  logic [2:0] mdiv_sel;
  logic [2:0] m_ratio;
  logic [3:0] sclk_ratio;
  logic [11:0] rate_div;
  logic [15:0] dm_per;
  logic [15:0] sclk_per;
  logic [15:0] sclk_half;
  logic [15:0] dm_cnt_reg;
  logic [15:0] sclk_cnt_reg;
  logic [11:0] rate_cnt_reg;
  logic dm_en;
  logic rise_en;
  logic fall_en;
  logic sw_rst_req;

  assign mdiv_sel = regs_reg.clock[ccwd_pkg::MDIV_HI:ccwd_pkg::MDIV_LO];

  always_comb begin
    m_ratio = 3'h1;
    if (mdiv_sel >= 3'h1 && mdiv_sel <= 3'h4) begin
      m_ratio = mdiv_sel + 3'h1;
    end
  end

  assign sclk_ratio = ccwd_pkg::SCLK_BASE >> regs_reg.clock[ccwd_pkg::SCLK_HI:ccwd_pkg::SCLK_LO];
  assign rate_div = ccwd_pkg::RATE_BASE >> regs_reg.clock[ccwd_pkg::RATE_HI:ccwd_pkg::RATE_LO];
  assign dm_per = 16'(SYS_PER_MCLK * int'(m_ratio));
  assign sclk_per = 16'(SYS_PER_MCLK * int'(m_ratio) * int'(sclk_ratio));
  assign sclk_half = sclk_per >> 1;
  assign dm_en = dm_cnt_reg >= dm_per - 16'h1;
  assign rise_en = sclk_cnt_reg >= sclk_per - 16'h1;
  assign fall_en = sclk_cnt_reg == sclk_half - 16'h1;

  always_ff @(posedge clk_sys) begin
    if (srst || dm_en || hw_rst || sw_rst_req) begin // Restart: reset spans four whole ticks
      dm_cnt_reg <= 16'h0;
    end else begin
      dm_cnt_reg <= dm_cnt_reg + 16'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || rise_en) begin
      sclk_cnt_reg <= 16'h0;
    end else begin
      sclk_cnt_reg <= sclk_cnt_reg + 16'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ser_clk <= 1'b1;
    end else if (rise_en) begin
      ser_clk <= 1'b1;
    end else if (fall_en) begin
      ser_clk <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rate_cnt_reg <= 12'h0;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (dm_en) begin
        if (rate_cnt_reg >= rate_div - 12'h1) begin
          rate_cnt_reg <= 12'h0;
          sample_tick <= 1'b1;
        end else begin
          rate_cnt_reg <= rate_cnt_reg + 12'h1;
        end
      end
    end
  end

  // ==========================================================
  // Reset sequencer
  logic [2:0] rst_cnt_reg;

  always_ff @(posedge clk_sys) begin
    if (srst || hw_rst || sw_rst_req) begin
      rst_cnt_reg <= ccwd_pkg::RESET_DIVIDED_MASTER_CLOCK;
    end else if (dm_en && rst_cnt_reg != 3'h0) begin
      rst_cnt_reg <= rst_cnt_reg - 3'h1;
    end
  end

  assign reset_busy = rst_cnt_reg != 3'h0;

  // ==========================================================
  // Receive shifter
  ccwd_pkg::ccwd_rx_t rx_state_reg;
  logic [15:0] rx_sh_reg;
  logic [3:0] rx_cnt_reg;
  logic [15:0] rx_word;
  logic word_done;

  assign rx_word = {rx_sh_reg[14:0], rx_data_s};
  assign word_done = fall_en && rx_state_reg == ccwd_pkg::RX_SHIFT && rx_cnt_reg == 4'hf;

  always_ff @(posedge clk_sys) begin
    if (srst || reset_busy) begin
      rx_state_reg <= ccwd_pkg::RX_IDLE;
      rx_sh_reg <= 16'h0;
      rx_cnt_reg <= 4'h0;
    end else if (fall_en) begin
      case (rx_state_reg)
        ccwd_pkg::RX_IDLE: begin
          if (rx_frame_s) begin
            rx_state_reg <= ccwd_pkg::RX_SHIFT;
            rx_cnt_reg <= 4'h0;
          end
        end
        ccwd_pkg::RX_SHIFT: begin
          rx_sh_reg <= rx_word;
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == 4'hf) begin
            rx_state_reg <= ccwd_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state_reg <= ccwd_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Word decode
  logic run_mode;
  logic mixed;
  logic is_ctl;
  logic is_data;
  logic hit;
  logic do_write;
  logic do_read;
  logic [2:0] dev;
  logic [2:0] radr;
  logic [7:0] rd_val;
  logic [15:0] tx_load;
  logic tx_req;

  assign run_mode = regs_reg.serial[ccwd_pkg::RUN_BIT];
  assign mixed = regs_reg.serial[ccwd_pkg::MIXED_BIT];
  assign dev = rx_word[ccwd_pkg::DEV_HI:ccwd_pkg::DEV_LO];
  assign radr = rx_word[ccwd_pkg::RADR_HI:ccwd_pkg::RADR_LO];

  always_comb begin
    // Plain data mode refuses every control word until srst or a pin reset
    is_ctl = word_done && rx_word[ccwd_pkg::CTL_BIT] && (!run_mode || mixed);
    is_data = word_done && ((run_mode && !mixed) || (mixed && !rx_word[ccwd_pkg::CTL_BIT]));
    hit = is_ctl && dev == ccwd_pkg::DEV_SELF;
    do_write = hit && !rx_word[ccwd_pkg::RW_BIT];
    do_read = hit && rx_word[ccwd_pkg::RW_BIT];
    sw_rst_req = do_write && radr == ccwd_pkg::ADR_SERIAL && rx_word[ccwd_pkg::SWRST_BIT];
    if (radr == ccwd_pkg::ADR_SERIAL) begin
      rd_val = regs_reg.serial;
    end else if (radr == ccwd_pkg::ADR_CLOCK) begin
      rd_val = regs_reg.clock;
    end else if (radr == ccwd_pkg::ADR_POWER) begin
      rd_val = regs_reg.power;
    end else if (radr == ccwd_pkg::ADR_GAIN) begin
      rd_val = regs_reg.gain;
    end else if (radr == ccwd_pkg::ADR_DAC) begin
      rd_val = regs_reg.dac;
    end else if (radr == ccwd_pkg::ADR_TAP) begin
      rd_val = regs_reg.tap;
    end else begin
      rd_val = ccwd_pkg::REG_RESET;
    end
    tx_req = 1'b1;
    if (is_ctl && !hit) begin
      tx_load = {rx_word[15:14], dev - 3'h1, rx_word[10:0]};
    end else if (do_read) begin
      tx_load = {rx_word[15:8], rd_val};
    end else if (do_write && regs_reg.clock[ccwd_pkg::ECHO_BIT]) begin
      tx_load = rx_word;
    end else if (is_data && regs_reg.serial[ccwd_pkg::SLOOP_BIT]) begin
      tx_load = rx_word;
    end else begin
      tx_load = 16'h0;
      tx_req = 1'b0;
    end
  end

  // ==========================================================
  // Register bank
  // Writes land on the serial clock fall that completes the word.
  always_ff @(posedge clk_sys) begin
    if (srst || reset_busy) begin
      regs_reg <= {6{ccwd_pkg::REG_RESET}};
    end else if (do_write && !sw_rst_req) begin
      if (radr == ccwd_pkg::ADR_SERIAL) begin
        regs_reg.serial <= rx_word[ccwd_pkg::DATA_HI:0] & ccwd_pkg::SERIAL_WMASK;
      end else if (radr == ccwd_pkg::ADR_CLOCK) begin
        regs_reg.clock <= rx_word[ccwd_pkg::DATA_HI:0];
      end else if (radr == ccwd_pkg::ADR_POWER) begin
        regs_reg.power <= rx_word[ccwd_pkg::DATA_HI:0] & ccwd_pkg::POWER_WMASK;
      end else if (radr == ccwd_pkg::ADR_GAIN) begin
        regs_reg.gain <= rx_word[ccwd_pkg::DATA_HI:0];
      end else if (radr == ccwd_pkg::ADR_DAC) begin
        regs_reg.dac <= rx_word[ccwd_pkg::DATA_HI:0];
      end else if (radr == ccwd_pkg::ADR_TAP) begin
        regs_reg.tap <= rx_word[ccwd_pkg::DATA_HI:0];
      end
      // Other addresses fall through untouched
    end
  end

  // ==========================================================
  // Data word path
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dac_word <= 16'h0;
      dac_valid <= 1'b0;
    end else begin
      dac_valid <= is_data;
      if (is_data) begin
        dac_word <= rx_word;
      end
    end
  end

  // ==========================================================
  // Transmit shifter
  // One pending slot only: a second reply before the first starts
  // replaces it, which the cascade protocol never provokes.
  ccwd_pkg::ccwd_tx_t tx_state_reg;
  logic [15:0] tx_pend_reg;
  logic tx_pend_vld_reg;
  logic [15:0] tx_sh_reg;
  logic [4:0] tx_cnt_reg;
  logic tx_start;

  assign tx_start = rise_en && tx_state_reg == ccwd_pkg::TX_IDLE && tx_pend_vld_reg && !reset_busy;

  always_ff @(posedge clk_sys) begin
    if (srst || reset_busy) begin
      tx_pend_reg <= 16'h0;
      tx_pend_vld_reg <= 1'b0;
    end else if (tx_req) begin
      tx_pend_reg <= tx_load;
      tx_pend_vld_reg <= 1'b1;
    end else if (tx_start) begin
      tx_pend_vld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_state_reg <= ccwd_pkg::TX_IDLE;
      tx_sh_reg <= 16'h0;
      tx_cnt_reg <= 5'h0;
      tx_frame <= 1'b0;
      tx_data <= 1'b0;
    end else if (rise_en) begin
      case (tx_state_reg)
        ccwd_pkg::TX_IDLE: begin
          tx_data <= 1'b0;
          tx_frame <= tx_start;
          if (tx_start) begin
            tx_sh_reg <= tx_pend_reg;
            tx_cnt_reg <= 5'(ccwd_pkg::WORD_W);
            tx_state_reg <= ccwd_pkg::TX_SHIFT;
          end
        end
        ccwd_pkg::TX_SHIFT: begin
          tx_frame <= 1'b0;
          tx_data <= tx_sh_reg[15];
          tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
          tx_cnt_reg <= tx_cnt_reg - 5'h1;
          if (tx_cnt_reg == 5'h1) begin
            tx_state_reg <= ccwd_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_state_reg <= ccwd_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Field outputs
  assign ctl.run_mode_select = regs_reg.serial[ccwd_pkg::RUN_BIT];
  assign ctl.mixed_mode_on = regs_reg.serial[ccwd_pkg::MIXED_BIT];
  assign ctl.digital_loopback = regs_reg.serial[ccwd_pkg::DLOOP_BIT];
  assign ctl.serial_port_loopback = regs_reg.serial[ccwd_pkg::SLOOP_BIT];
  assign ctl.cascade_count = regs_reg.serial[ccwd_pkg::CASC_HI:ccwd_pkg::CASC_LO];
  assign ctl.sample_rate_sel = regs_reg.clock[ccwd_pkg::RATE_HI:ccwd_pkg::RATE_LO];
  assign ctl.serial_clock_sel = regs_reg.clock[ccwd_pkg::SCLK_HI:ccwd_pkg::SCLK_LO];
  assign ctl.master_divide_sel = mdiv_sel;
  assign ctl.control_echo_on = regs_reg.clock[ccwd_pkg::ECHO_BIT];
  assign ctl.global_power_on = regs_reg.power[ccwd_pkg::PWR_ALL_BIT];
  assign ctl.analog_tap_power = regs_reg.power[ccwd_pkg::PWR_TAP_BIT];
  assign ctl.input_amp_power = regs_reg.power[ccwd_pkg::PWR_AMP_BIT];
  assign ctl.adc_power = regs_reg.power[ccwd_pkg::PWR_ADC_BIT];
  assign ctl.dac_power = regs_reg.power[ccwd_pkg::PWR_DAC_BIT];
  assign ctl.reference_power = regs_reg.power[ccwd_pkg::PWR_REF_BIT];
  assign ctl.reference_pin_drive = regs_reg.power[ccwd_pkg::REF_PIN_BIT];
  assign ctl.input_gain_sel = regs_reg.gain[ccwd_pkg::IGAIN_HI:ccwd_pkg::IGAIN_LO];
  assign ctl.modulator_reset = regs_reg.gain[ccwd_pkg::MODRST_BIT];
  assign ctl.output_gain_sel = regs_reg.gain[ccwd_pkg::OGAIN_HI:ccwd_pkg::OGAIN_LO];
  assign ctl.output_mute = regs_reg.gain[ccwd_pkg::QUIET_BIT];
  assign ctl.dac_advance = regs_reg.dac[ccwd_pkg::ADV_HI:ccwd_pkg::ADV_LO];
  assign ctl.interpolator_bypass = regs_reg.dac[ccwd_pkg::BYPASS_BIT];
  assign ctl.digital_tap_enable = regs_reg.dac[ccwd_pkg::DTAP_BIT];
  assign ctl.test_mode_on = regs_reg.dac[ccwd_pkg::TEST_BIT];
  assign ctl.analog_tap_coef = regs_reg.tap[ccwd_pkg::COEF_HI:ccwd_pkg::COEF_LO];
  assign ctl.single_ended_input = regs_reg.tap[ccwd_pkg::SINGLE_BIT];
  assign ctl.analog_tap_enable = regs_reg.tap[ccwd_pkg::SINGLE_BIT];
  assign ctl.input_polarity_flip = regs_reg.tap[ccwd_pkg::FLIP_BIT];
  assign ctl.analog_loopback = regs_reg.tap[ccwd_pkg::LOOP_OUT_BIT];
  assign ctl.analog_tap_mute = regs_reg.tap[ccwd_pkg::LOOP_OUT_BIT];

endmodule : ccwd_decoder
`default_nettype wire

// *** sim/ccwd_host_model.sv ***
// Host serial port model: sends control words, collects replies
`timescale 1ns/10ps
`default_nettype none
module ccwd_host_model (
  input wire logic ser_clk,
  input wire logic tx_data,
  input wire logic tx_frame,
  output logic rx_data,
  output logic rx_frame
);
  logic busy = 1'b0;
  logic [15:0] sh;
  int cnt = 0;
  logic [15:0] got[$];
  initial begin
    rx_data = 1'b0;
    rx_frame = 1'b0;
  end
  // ==========================================
  // Transmit to the device
  // Idle line toggles so a stale bit never passes for data
  always @(posedge ser_clk) if (!busy) rx_data <= #1 ~rx_data;
  // Frame sync one period ahead, then bit 15 first
  task automatic send(input logic [15:0] w);
    busy = 1'b1;
    @(posedge ser_clk) #1 rx_frame = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(posedge ser_clk) #1 rx_frame = 1'b0;
      rx_data = w[i];
    end
    @(posedge ser_clk) #1 rx_data = ~w[0];
    busy = 1'b0;
  endtask : send
  // ==========================================
  // Receive from the device, sampled mid-bit on the fall
  always @(negedge ser_clk) begin
    if (cnt == 0) begin
      if (tx_frame === 1'b1) cnt = 16;
    end else begin
      sh = {sh[14:0], tx_data};
      cnt = cnt - 1;
      if (cnt == 0) got.push_back(sh);
    end
  end
endmodule : ccwd_host_model
`default_nettype wire

// *** sim/ccwd_decoder_checker.sv ***
// Concurrent checks on the control word decoder ports
`timescale 1ns/10ps
`default_nettype none
module ccwd_decoder_checker #(
  parameter int SYS_PER_MCLK = ccwd_pkg::SYS_PER_MCLK
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic areset_n,
  input wire logic rx_data,
  input wire logic rx_frame,
  input wire logic ser_clk,
  input wire logic tx_data,
  input wire logic tx_frame,
  input wire ccwd_pkg::ccwd_ctl_t ctl,
  input wire logic [15:0] dac_word,
  input wire logic dac_valid,
  input wire logic sample_tick,
  input wire logic reset_busy
);
  int busy_run;
  logic sclk_q;
  logic sclk_qq;
  always_ff @(posedge clk_sys) begin
    busy_run <= (srst || !reset_busy) ? 0 : busy_run + 1;
  end
  always_ff @(posedge clk_sys) begin
    sclk_q <= ser_clk;
    sclk_qq <= sclk_q;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ==========================================
  // Assertions
  a_srst_quiet: assert property (disable iff (1'b0)
    srst |=> reset_busy && ser_clk && !tx_frame && !dac_valid && !sample_tick)
    else $error("srst left outputs active");
  // Upper bound leaves room for a short pin pulse
  a_busy_span: assert property ($fell(reset_busy) |->
    busy_run inside {[4 * SYS_PER_MCLK : 20 * SYS_PER_MCLK + 16]})
    else $error("reset busy span out of range");
  a_busy_clears: assert property (reset_busy [*2] |-> ctl == '0)
    else $error("fields not cleared in reset");
  a_write_on_fall: assert property (
    !reset_busy && !$past(reset_busy) && $changed(ctl) |->
    (sclk_q && !ser_clk) || (sclk_qq && !sclk_q))
    else $error("fields changed away from a serial clock fall");
  a_dac_pulse: assert property (
    dac_valid |-> (ctl.run_mode_select || ctl.mixed_mode_on) ##1 !dac_valid)
    else $error("data strobe outside data modes or too long");
  a_tick_gap: assert property (sample_tick |=> !sample_tick [*8])
    else $error("sample ticks too close");
  a_frame_rise: assert property ($rose(tx_frame) |-> $rose(ser_clk))
    else $error("output frame not on a serial clock rise");
  a_frame_end: assert property ($fell(tx_frame) |-> $rose(ser_clk))
    else $error("output frame not one serial clock long");
  c_data_word: cover property (dac_valid);
  c_reply: cover property ($rose(tx_frame));
  c_reset_done: cover property ($fell(reset_busy));
endmodule : ccwd_decoder_checker
bind ccwd_decoder ccwd_decoder_checker #(.SYS_PER_MCLK(SYS_PER_MCLK)) u_ccwd_decoder_checker (
  .clk_sys(clk_sys), .srst(srst), .areset_n(areset_n), .rx_data(rx_data),
  .rx_frame(rx_frame), .ser_clk(ser_clk), .tx_data(tx_data), .tx_frame(tx_frame),
  .ctl(ctl), .dac_word(dac_word), .dac_valid(dac_valid), .sample_tick(sample_tick),
  .reset_busy(reset_busy));
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the control word decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int SPM = 2;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic areset_n = 1'b1;
  logic rx_data, rx_frame, ser_clk, tx_data, tx_frame, dac_valid, sample_tick, reset_busy;
  logic [15:0] dac_word;
  logic [15:0] dac_last;
  ccwd_pkg::ccwd_ctl_t ctl;
  logic [7:0] rm [6];
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  ccwd_decoder #(.SYS_PER_MCLK(SPM)) u_ccwd_decoder (
    .clk_sys(clk_sys), .srst(srst), .areset_n(areset_n), .rx_data(rx_data),
    .rx_frame(rx_frame), .ser_clk(ser_clk), .tx_data(tx_data), .tx_frame(tx_frame),
    .ctl(ctl), .dac_word(dac_word), .dac_valid(dac_valid), .sample_tick(sample_tick),
    .reset_busy(reset_busy));
  ccwd_host_model u_ccwd_host_model (.ser_clk(ser_clk), .tx_data(tx_data),
    .tx_frame(tx_frame), .rx_data(rx_data), .rx_frame(rx_frame));
  always @(posedge clk_sys) begin
    cyc++;
    if (dac_valid === 1'b1) dac_last = dac_word;
    if (cyc == 100000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ==========================================
  // Checks and expectations
  task automatic give_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string m);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk16
  task automatic chk_n(input int g, input int e, input string m);
    checked++;
    if (g != e) begin
      fail_count++;
      $display("MISMATCH %0t %s got %0d exp %0d", $time, m, g, e);
    end
  endtask : chk_n
  function automatic ccwd_pkg::ccwd_ctl_t exp_ctl();
    logic [7:0] a, b, c, d, e, f;
    {a, b, c, d, e, f} = {rm[0], rm[1], rm[2], rm[3], rm[4], rm[5]};
    return {a[0], a[1], a[2], a[3], a[6:4], b[1:0], b[3:2], b[6:4], b[7], c[0], c[1],
      c[2], c[3], c[4], c[5], c[6], d[2:0], d[3], d[6:4], d[7], e[4:0], e[5], e[6],
      e[7], f[4:0], f[5], f[5], f[6], f[7], f[7]};
  endfunction : exp_ctl
  task automatic chk_ctl();
    checked++;
    if (ctl !== exp_ctl()) begin
      fail_count++;
      $display("MISMATCH %0t fields got %h exp %h", $time, ctl, exp_ctl());
    end
  endtask : chk_ctl
  // Keeps data mode, reset, every serial clock but divide-by-8 and the reserved bit out
  function automatic logic [7:0] msk(input logic [2:0] a);
    return a == 0 ? 8'h7e : a == 1 ? 8'h73 : a == 2 ? 8'h7f : 8'hff;
  endfunction : msk
  // ==========================================
  // Stimulus helpers
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    u_ccwd_host_model.send({2'b10, 3'h0, a, v});
    if (a < 3'h6) rm[a] = v;
  endtask : wr
  task automatic expect_tx(input logic [15:0] w);
    int n;
    n = 0;
    while (u_ccwd_host_model.got.size() == 0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 4000) chk_n(0, 1, "reply missing");
    else chk16(u_ccwd_host_model.got.pop_front(), w, "reply word");
  endtask : expect_tx
  task automatic settle();
    repeat (24) @(posedge ser_clk);
    u_ccwd_host_model.got.delete();
  endtask : settle
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge clk_sys);
    while (reset_busy !== 1'b0 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    rm = '{default: 8'h00};
  endtask : wait_idle
  task automatic next_tick();
    do @(posedge clk_sys); while (sample_tick !== 1'b1);
  endtask : next_tick
  // ==========================================
  // Main sequence
  initial begin
    logic [2:0] a;
    logic [15:0] w;
    time t;
    void'($urandom(975));
    rm = '{default: 8'h00};
    repeat (4) @(posedge clk_sys);
    #1 srst = 1'b0;
    wait_idle();
    chk_ctl();
    repeat (14) begin
      a = 3'($urandom % 6);
      wr(a, 8'($urandom) & msk(a));
      chk_ctl();
      w = {2'b11, 3'h0, a, 8'($urandom)};
      u_ccwd_host_model.send(w);
      expect_tx({w[15:8], rm[a]});
    end
    for (int d = 1; d < 8; d++) begin
      w = {1'b1, 1'($urandom), 3'(d), 11'($urandom)};
      u_ccwd_host_model.send(w);
      expect_tx({w[15:14], 3'(d - 1), w[10:0]});
    end
    chk_ctl();
    wr(3'h6, 8'($urandom));
    chk_ctl();
    u_ccwd_host_model.send(16'hc7a5);
    expect_tx(16'hc700);
    wr(3'h0, 8'h00);
    u_ccwd_host_model.send({1'b0, 15'($urandom)});
    repeat (24) @(posedge ser_clk);
    chk_n(u_ccwd_host_model.got.size(), 0, "ignored word answered");
    chk_ctl();
    wr(3'h1, 8'h80);
    settle();
    w = {2'b10, 3'h0, 3'h3, 8'($urandom)};
    wr(3'h3, w[7:0]);
    expect_tx(w);
    wr(3'h1, 8'h00);
    settle();
    for (int i = 0; i < 4; i++) begin
      wr(3'h1, 8'(i * 5));
      @(posedge ser_clk) t = $time;
      @(posedge ser_clk);
      chk_n(int'(($time - t) / 10), (8 >> i) * SPM, "serial period");
      next_tick();
      t = $time;
      next_tick();
      chk_n(int'(($time - t) / 10), (2048 >> i) * SPM, "sample period");
    end
    wr(3'h1, 8'h05);
    wr(3'h3, 8'h5a);
    u_ccwd_host_model.send(16'h8080);
    wait_idle();
    chk_ctl();
    @(posedge ser_clk) t = $time;
    @(posedge ser_clk);
    chk_n(int'(($time - t) / 10), 8 * SPM, "default serial period");
    wr(3'h4, 8'h3c);
    @(posedge clk_sys) #1 areset_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 areset_n = 1'b1;
    wait_idle();
    chk_ctl();
    wr(3'h0, 8'h01);
    w = 16'($urandom);
    u_ccwd_host_model.send(w);
    settle();
    chk16(dac_last, w, "data word");
    u_ccwd_host_model.send(16'h83ff);
    settle();
    chk16(dac_last, 16'h83ff, "control word as data");
    chk_ctl();
    @(posedge clk_sys) #1 srst = 1'b1;
    @(posedge clk_sys) #1 srst = 1'b0;
    wait_idle();
    wr(3'h0, 8'h0a);
    w = {1'b0, 15'($urandom)};
    u_ccwd_host_model.send(w);
    expect_tx(w);
    chk16(dac_last, w, "mixed data word");
    wr(3'h3, 8'ha5);
    chk_ctl();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
